// ===== inc/bpl_cfg.svh
`ifndef BPL_CFG_SVH
`define BPL_CFG_SVH

// ****************************************
// register map
// ****************************************
`define BPL_ADDR_NODE_ID     4'h0
`define BPL_ADDR_DRV_CTRL    4'h1
`define BPL_ADDR_RSVD3       4'h3
`define BPL_ADDR_PRIORITY    4'h4
`define BPL_INHIBIT_BIT      0
`define BPL_IBR_BIT          1
`define BPL_NODE_ID_RESET    6'h00
`define BPL_PRIORITY_RESET   4'h0

// ****************************************
// serial request format
// ****************************************
`define BPL_REQ_READ         3'h4
`define BPL_REQ_WRITE        3'h5
`define BPL_LEN_READ         5'h09
`define BPL_LEN_WRITE        5'h11
`define BPL_LEN_BUSREQ       5'h0B
`define BPL_TYPE_LAST_IDX    5'h03

// ****************************************
// control line codes
// ****************************************
`define BPL_CTL_IDLE         2'h0
`define BPL_CTL_STATUS       2'h1
`define BPL_CTL_RECEIVE      2'h2
`define BPL_CTL_GRANT        2'h3
`define BPL_LCTL_RELEASE     2'h0
`define BPL_LCTL_TRANSMIT    2'h2

// ****************************************
// timing
// ****************************************
`define BPL_CLK_MHZ          125
`define BPL_BUS_RESET_NS     2000
`define BPL_BUS_RESET_CYC    ((`BPL_BUS_RESET_NS * `BPL_CLK_MHZ) / 1000)
`define BPL_STATUS_DIBITS    4'h6
`define BPL_ARB_BITS         4'hA

`endif

// ===== inc/bpl_pkg.sv
package bpl_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_STATUS,
        ST_RECV,
        ST_ARB,
        ST_GRANT
    } bpl_state_e;

    typedef struct packed {
        logic       last;
        logic [1:0] dibit;
    } bpl_rx_word_s;

    typedef struct packed {
        logic [1:0] data;
        logic       strobe;
        logic       enable;
    } bpl_tx_s;

endpackage

// ===== core/bpl_phy_link.sv
`timescale 1ns/1ps
`include "bpl_cfg.svh"

// ****************************************
// receive buffer
// ****************************************
module bpl_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             full_q, full_d, empty_q, empty_d, push, pop;

    always_comb begin
        push    = in_valid && !full_q;
        pop     = out_ready && !empty_q;
        wr_d    = push ? wr_q + 1'b1 : wr_q;
        rd_d    = pop ? rd_q + 1'b1 : rd_q;
        cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        full_d  = cnt_d == (AW+1)'(DEPTH);
        empty_d = cnt_d == '0;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            full_q  <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            cnt_q   <= cnt_d;
            full_q  <= full_d;
            empty_q <= empty_d;
        end
    end

    // storage needs no reset; empty flag guards reads
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    assign in_ready  = !full_q;
    assign out_valid = !empty_q;
    assign out_data  = mem[rd_q];
endmodule // bpl_fifo

// ****************************************
// phy side of the phy-link interface
// ****************************************
module bpl_phy_link
    import bpl_pkg::*;
#(
    parameter int RESET_CYCLES = `BPL_BUS_RESET_CYC,
    parameter int RX_DEPTH     = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // link interface
    output logic              sclk,
    input  wire logic         lreq,
    input  wire logic [1:0]   d_in,
    output logic      [1:0]   d_out,
    output logic              d_oe,
    input  wire logic [1:0]   ctl_in,
    output logic      [1:0]   ctl_out,
    output logic              ctl_oe,
    // backplane arbitration line
    output logic              arb_tx,
    output logic              arb_oe,
    input  wire logic         arb_rx,
    // received packet stream from the serial bus
    input  wire bpl_rx_word_s rx_word,
    input  wire logic         rx_valid,
    output logic              rx_ready,
    // transmit toward the backplane
    output bpl_tx_s           tx,
    output logic              bus_reset_active
);
    generate
        if (RESET_CYCLES < 1) begin : g_bad_reset
            $error("bus reset must last at least one cycle");
        end
    endgenerate

    bpl_rx_word_s fifo_word;
    logic         fifo_valid, fifo_pop, fifo_ready;

    bpl_fifo #(.WIDTH($bits(bpl_rx_word_s)), .DEPTH(RX_DEPTH)) u_rx_fifo (
        .clk      (clk),
        .reset    (reset),
        .in_data  (rx_word),
        .in_valid (rx_valid),
        .in_ready (fifo_ready),
        .out_data (fifo_word),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    function automatic logic [7:0] reg_read(input logic [3:0] a, input logic [5:0] id,
                                            input logic inh, input logic initiate_bus_reset, input logic [3:0] pri);
        case (a)
            `BPL_ADDR_NODE_ID:  reg_read = {2'h0, id};
            `BPL_ADDR_DRV_CTRL: reg_read = {6'h00, initiate_bus_reset, inh};
            `BPL_ADDR_PRIORITY: reg_read = {4'h0, pri};
            default:            reg_read = 8'h00;
        endcase
    endfunction

    // ****************************************
    // state
    // ****************************************
    bpl_state_e  st_q, st_d;
    logic        sclk_q, sclk_d, tick;
    logic [5:0]  id_q, id_d;
    logic        inh_q, inh_d, ibr_q, ibr_d;
    logic [3:0]  pri_q, pri_d;
    logic [31:0] rcnt_q, rcnt_d;
    logic        rq_busy_q, rq_busy_d;
    logic [4:0]  rq_cnt_q, rq_cnt_d, rq_len_q, rq_len_d;
    logic [14:0] rq_sh_q, rq_sh_d;
    logic        rd_pend_q, rd_pend_d, bus_pend_q, bus_pend_d;
    logic [3:0]  rd_addr_q, rd_addr_d, req_pri_q, req_pri_d, cnt_q, cnt_d;
    logic [11:0] sh_q, sh_d;
    logic [9:0]  arb_q, arb_d;
    logic [1:0]  d_q, d_d, ctl_q, ctl_d;
    logic        d_oe_q, d_oe_d, ctl_oe_q, ctl_oe_d, atx_q, atx_d, aoe_q, aoe_d;
    logic        rdy_q, rdy_d;
    bpl_tx_s     tx_q, tx_d;
    logic        wr_ibr, rd_set, bus_set;

    always_comb begin
        st_d = st_q;  id_d = id_q;  inh_d = inh_q;  ibr_d = ibr_q;  pri_d = pri_q;
        rcnt_d = rcnt_q;  rq_busy_d = rq_busy_q;  rq_cnt_d = rq_cnt_q;  rq_len_d = rq_len_q;
        rq_sh_d = rq_sh_q;  rd_pend_d = rd_pend_q;  bus_pend_d = bus_pend_q;
        rd_addr_d = rd_addr_q;  req_pri_d = req_pri_q;  cnt_d = cnt_q;  sh_d = sh_q;
        arb_d = arb_q;  d_d = d_q;  ctl_d = ctl_q;  d_oe_d = d_oe_q;  ctl_oe_d = ctl_oe_q;
        atx_d = atx_q;  aoe_d = aoe_q;  tx_d = tx_q;  fifo_pop = 1'b0;  wr_ibr = 1'b0;
        rd_set = 1'b0;  bus_set = 1'b0;
        rdy_d = fifo_ready;
        tick   = !sclk_q;  // next edge raises sclk
        sclk_d = !sclk_q;

        if (tick) begin
            // serial request deserialiser, msb first, idles low
            if (!rq_busy_q) begin
                if (lreq) begin
                    rq_busy_d = 1'b1;
                    rq_cnt_d  = 5'h01;
                    rq_sh_d   = '0;
                end
            end else begin
                rq_sh_d  = {rq_sh_q[13:0], lreq};
                rq_cnt_d = rq_cnt_q + 5'h01;
                if (rq_cnt_q == `BPL_TYPE_LAST_IDX) begin
                    case ({rq_sh_q[1:0], lreq})
                        `BPL_REQ_READ:  rq_len_d = `BPL_LEN_READ;
                        `BPL_REQ_WRITE: rq_len_d = `BPL_LEN_WRITE;
                        default:        rq_len_d = `BPL_LEN_BUSREQ;
                    endcase
                end
                if (rq_cnt_q > `BPL_TYPE_LAST_IDX && rq_cnt_q == rq_len_q - 5'h01) begin
                    rq_busy_d = 1'b0;
                    if (!lreq) begin // bad stop bit drops the request
                        if (rq_len_q == `BPL_LEN_READ) begin
                            rd_pend_d = 1'b1;
                            rd_set    = 1'b1;
                            rd_addr_d = rq_sh_q[3:0];
                        end else if (rq_len_q == `BPL_LEN_WRITE) begin
                            case (rq_sh_q[11:8])
                                `BPL_ADDR_NODE_ID:  id_d  = rq_sh_q[5:0];
                                `BPL_ADDR_DRV_CTRL: begin
                                    inh_d  = rq_sh_q[`BPL_INHIBIT_BIT];
                                    ibr_d  = rq_sh_q[`BPL_IBR_BIT];
                                    wr_ibr = rq_sh_q[`BPL_IBR_BIT];
                                end
                                `BPL_ADDR_PRIORITY: pri_d = rq_sh_q[3:0];
                                default: ;
                            endcase
                        end else begin
                            bus_pend_d = 1'b1;
                            bus_set    = 1'b1;
                            // all ones is reserved, zero falls back to register
                            req_pri_d  = (rq_sh_q[3:0] == 4'h0 || rq_sh_q[3:0] == 4'hF) ? pri_q : rq_sh_q[3:0];
                        end
                    end
                end
            end

            case (st_q)
                ST_IDLE: begin
                    ctl_d = `BPL_CTL_IDLE;  ctl_oe_d = 1'b1;  d_d = 2'h0;  d_oe_d = 1'b1;
                    if (fifo_valid) begin
                        st_d = ST_RECV;  ctl_d = `BPL_CTL_RECEIVE;  d_d = fifo_word.dibit;  fifo_pop = 1'b1;
                        if (fifo_word.last) begin
                            st_d = ST_IDLE;
                        end
                    end else if (rd_pend_q) begin
                        rd_pend_d = rd_set; // a read ending on this tick stays pending
                        st_d  = ST_STATUS;
                        ctl_d = `BPL_CTL_STATUS;
                        sh_d  = {rd_addr_q, reg_read(rd_addr_q, id_q, inh_q, ibr_q, pri_q)};
                        d_d   = sh_d[11:10];
                        sh_d  = {sh_d[9:0], 2'h0};
                        cnt_d = `BPL_STATUS_DIBITS - 4'h1;
                    end else if (bus_pend_q) begin
                        st_d  = ST_ARB;
                        arb_d = {req_pri_q, id_q};
                        atx_d = arb_d[9];  aoe_d = 1'b1;
                        arb_d = {arb_d[8:0], 1'b0};
                        cnt_d = `BPL_ARB_BITS - 4'h1;
                    end
                end
                ST_STATUS: begin
                    if (cnt_q == 4'h0) begin
                        st_d = ST_IDLE;  ctl_d = `BPL_CTL_IDLE;  d_d = 2'h0;
                    end else begin
                        d_d = sh_q[11:10];  sh_d = {sh_q[9:0], 2'h0};  cnt_d = cnt_q - 4'h1;
                    end
                end
                ST_RECV: begin
                    d_d = 2'h0;
                    if (fifo_valid) begin // starved buffer holds receive code with zero data
                        d_d = fifo_word.dibit;  fifo_pop = 1'b1;
                        if (fifo_word.last) begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_ARB: begin
                    if (arb_rx != atx_q) begin
                        st_d = ST_IDLE;  atx_d = 1'b0;  aoe_d = 1'b0;
                    end else if (atx_q || cnt_q == 4'h0) begin
                        // a one read back, or an all-zero code against an all-zero bus: nobody beat us
                        st_d = ST_GRANT;  atx_d = 1'b0;  aoe_d = 1'b0;  bus_pend_d = bus_set;
                        ctl_d = `BPL_CTL_GRANT;
                    end else begin
                        atx_d = arb_q[9];  arb_d = {arb_q[8:0], 1'b0};  cnt_d = cnt_q - 4'h1;
                    end
                end
                ST_GRANT: begin
                    ctl_oe_d = 1'b0;  d_oe_d = 1'b0;
                    tx_d.enable = 1'b0;  tx_d.strobe = 1'b0;  tx_d.data = 2'h0;
                    if (ctl_oe_q == 1'b0 && ctl_in == `BPL_LCTL_RELEASE) begin
                        st_d = ST_IDLE;  ctl_oe_d = 1'b1;  d_oe_d = 1'b1;  ctl_d = `BPL_CTL_IDLE;
                    end else if (ctl_oe_q == 1'b0 && ctl_in == `BPL_LCTL_TRANSMIT) begin
                        tx_d.enable = 1'b1;  tx_d.strobe = 1'b1;  tx_d.data = d_in;
                    end
                end
                default: st_d = ST_IDLE;
            endcase
            if (st_q != ST_GRANT) begin
                tx_d = '0;
            end
        end
        if (inh_d) begin
            tx_d = '0;
        end

        if (ibr_q) begin
            rcnt_d = rcnt_q + 32'd1;
            if (rcnt_q == 32'(RESET_CYCLES - 1)) begin
                rcnt_d = '0;
                if (!wr_ibr) begin
                    ibr_d = 1'b0; // new set in the same cycle wins
                end
            end
        end else begin
            rcnt_d = '0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= ST_IDLE;  sclk_q <= 1'b0;  id_q <= `BPL_NODE_ID_RESET;  inh_q <= 1'b0;
            ibr_q <= 1'b0;  pri_q <= `BPL_PRIORITY_RESET;  rcnt_q <= '0;  rq_busy_q <= 1'b0;
            rq_cnt_q <= '0;  rq_len_q <= `BPL_LEN_BUSREQ;  rq_sh_q <= '0;  rd_pend_q <= 1'b0;
            bus_pend_q <= 1'b0;  rd_addr_q <= '0;  req_pri_q <= '0;  cnt_q <= '0;  sh_q <= '0;
            arb_q <= '0;  d_q <= 2'h0;  ctl_q <= `BPL_CTL_IDLE;  d_oe_q <= 1'b1;  ctl_oe_q <= 1'b1;
            atx_q <= 1'b0;  aoe_q <= 1'b0;  tx_q <= '0;  rdy_q <= 1'b0;
        end else begin
            st_q <= st_d;  sclk_q <= sclk_d;  id_q <= id_d;  inh_q <= inh_d;
            ibr_q <= ibr_d;  pri_q <= pri_d;  rcnt_q <= rcnt_d;  rq_busy_q <= rq_busy_d;
            rq_cnt_q <= rq_cnt_d;  rq_len_q <= rq_len_d;  rq_sh_q <= rq_sh_d;  rd_pend_q <= rd_pend_d;
            bus_pend_q <= bus_pend_d;  rd_addr_q <= rd_addr_d;  req_pri_q <= req_pri_d;  cnt_q <= cnt_d;
            sh_q <= sh_d;  arb_q <= arb_d;  d_q <= d_d;  ctl_q <= ctl_d;  d_oe_q <= d_oe_d;
            ctl_oe_q <= ctl_oe_d;  atx_q <= atx_d;  aoe_q <= aoe_d;  tx_q <= tx_d;  rdy_q <= rdy_d;
        end
    end

    assign sclk             = sclk_q;
    assign d_out            = d_q;
    assign d_oe             = d_oe_q;
    assign ctl_out          = ctl_q;
    assign ctl_oe           = ctl_oe_q;
    assign arb_tx           = atx_q;
    assign arb_oe           = aoe_q;
    assign tx               = tx_q;
    assign bus_reset_active = ibr_q;
    // registered copy of buffer ready; a word offered in the one late cycle is dropped because push checks full itself
    assign rx_ready         = rdy_q;
endmodule // bpl_phy_link

// ===== tb/bpl_phy_link_assertions.sv
`timescale 1ns/1ps
// ****
// phy-link port checks
// ****
module bpl_phy_link_assertions
    import bpl_pkg::*;
#(
    parameter int RESET_CYCLES = 250
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // link side
    input wire logic       sclk,
    input wire logic [1:0] d_in,
    input wire logic       d_oe,
    input wire logic [1:0] ctl_in,
    input wire logic [1:0] ctl_out,
    input wire logic       ctl_oe,
    // arbitration, buffer, transmit
    input wire logic       arb_tx,
    input wire logic       arb_oe,
    input wire logic       arb_rx,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire bpl_tx_s    tx,
    input wire logic       bus_reset_active
);
    int unsigned ibr_cnt_q, ibr_cnt_d;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // a bus reset that never ends shows up as a runaway count
    always_comb begin
        ibr_cnt_d = bus_reset_active ? ibr_cnt_q + 1 : 0;
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            ibr_cnt_q <= 0;
        else
            ibr_cnt_q <= ibr_cnt_d;
    end
    a_sclk_toggle: assert property (!$past(reset) |-> sclk != $past(sclk))
        else $error("sclk missed a toggle");
    a_ctl_on_tick: assert property ($changed(ctl_out) |-> !$past(sclk))
        else $error("control code moved off a tick");
    a_arb_on_tick: assert property ($changed(arb_oe) |-> !$past(sclk))
        else $error("arbitration enable moved off a tick");
    a_arb_drop: assert property (!sclk && arb_oe && arb_rx != arb_tx |=> !arb_oe)
        else $error("stayed in arbitration after mismatch");
    a_arb_win: assert property (!sclk && arb_oe && arb_tx && arb_rx |-> ##[1:2] ctl_out == 2'h3)
        else $error("one read back did not win");
    a_grant_hand: assert property (ctl_oe && ctl_out == 2'h3 |-> ##[1:2] !ctl_oe && !d_oe)
        else $error("grant without handing over lines");
    a_tx_follow: assert property ($rose(tx.enable) |-> $past(ctl_in) == 2'h2 && tx.data == $past(d_in))
        else $error("transmit word not from link data");
    a_recv_start: assert property (rx_valid && rx_ready && ctl_oe && ctl_out == 2'h0 && !arb_oe
        |-> ##[1:40] ctl_out == 2'h2)
        else $error("receive not started");
    a_ibr_bounded: assert property (ibr_cnt_q <= RESET_CYCLES + 1)
        else $error("bus reset did not clear");
    c_win: cover property (ctl_oe && ctl_out == 2'h3);
    c_drop: cover property (!sclk && arb_oe && arb_rx != arb_tx);
    c_full: cover property ($fell(rx_ready));
    c_ibr: cover property ($fell(bus_reset_active));
endmodule // bpl_phy_link_assertions

bind bpl_phy_link bpl_phy_link_assertions #(.RESET_CYCLES(RESET_CYCLES)) u_checks (
    .clk(clk), .reset(reset), .sclk(sclk), .d_in(d_in), .d_oe(d_oe), .ctl_in(ctl_in),
    .ctl_out(ctl_out), .ctl_oe(ctl_oe), .arb_tx(arb_tx), .arb_oe(arb_oe), .arb_rx(arb_rx),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx(tx), .bus_reset_active(bus_reset_active)
);

// ===== tb/bpl_link_model.sv
`timescale 1ns/1ps
// ****
// link partner
// ****
module bpl_link_model (
    // phy side
    input  wire logic       sclk,
    input  wire logic [1:0] ctl_out,
    input  wire logic [1:0] d_out,
    // link drive
    output logic            lreq,
    output logic            l_oe,
    output logic      [1:0] l_ctl,
    output logic      [1:0] l_d
);
    logic [1:0] rxq[$];
    initial begin
        lreq  = 1'h0;
        l_oe  = 1'h0;
        l_ctl = 2'h0;
        l_d   = 2'h0;
    end
    // phy samples at the sclk rise, so move 1 ns after it
    task automatic tick();
        @(posedge sclk);
        #1;
    endtask
    // start bit first, line parked low after
    task automatic send(input logic [16:0] bits, input int len);
        for (int i = len - 1; i >= 0; i--) begin
            lreq = bits[i];
            tick();
        end
        // a bad stop bit leaves the line high; park it low for one tick
        if (bits[0]) begin
            lreq = 1'h0;
            tick();
        end
    endtask
    task automatic wait_ctl(input logic [1:0] c, output bit ok);
        ok = 1'b0;
        for (int n = 0; n < 60 && !ok; n++) begin
            ok = ctl_out === c;
            if (!ok)
                tick();
        end
    endtask
    task automatic status(output logic [11:0] w, output bit ok);
        w = 12'h000;
        wait_ctl(2'h1, ok);
        for (int i = 0; i < 6; i++) begin
            w = {w[9:0], d_out};
            tick();
        end
    endtask
    // lines are ours only from the tick after the grant code
    task automatic grant(output bit ok);
        wait_ctl(2'h3, ok);
        tick();
        l_oe  = ok;
        l_ctl = 2'h1; // hold for one tick before sending
        tick();
    endtask
    task automatic xmit(input logic [1:0] d);
        l_ctl = 2'h2;
        l_d   = d;
        tick();
    endtask
    task automatic release_bus();
        l_ctl = 2'h0;
        tick();
        l_oe = 1'h0;
    endtask
    always @(posedge sclk) begin
        #1;
        if (ctl_out === 2'h2)
            rxq.push_back(d_out);
    end
endmodule // bpl_link_model

// ===== tb/bpl_phy_link_test.sv
`timescale 1ns/1ps
// ****
// phy-link block test
// ****
module bpl_phy_link_test
    import bpl_pkg::*;
;
    localparam int RC = 8;
    localparam logic [16:0] BUS_REQ = {6'h00, 1'h1, 3'h3, 2'h0, 4'h0, 1'h0};
    logic         clk, reset, sclk, lreq, d_oe, ctl_oe, arb_tx, arb_oe, arb_rx;
    logic         rx_valid, rx_ready, bus_reset_active, l_oe, rival, full;
    logic   [1:0] d_in, d_out, ctl_in, ctl_out, l_ctl, l_d;
    logic  [11:0] w;
    bit           ok;
    bpl_rx_word_s rx_word;
    bpl_tx_s      tx;
    int           n_errors, n_checks, k;
    // whoever holds the enable owns the wire; nobody driving gives a moving pattern
    assign d_in   = d_oe ? d_out : l_oe ? l_d : {clk, ~clk};
    assign ctl_in = ctl_oe ? ctl_out : l_oe ? l_ctl : {clk, ~clk};
    assign arb_rx = (arb_oe & arb_tx) | rival;
    bpl_phy_link #(.RESET_CYCLES(RC), .RX_DEPTH(16)) DUT (
        .clk(clk), .reset(reset), .sclk(sclk), .lreq(lreq), .d_in(d_in), .d_out(d_out),
        .d_oe(d_oe), .ctl_in(ctl_in), .ctl_out(ctl_out), .ctl_oe(ctl_oe), .arb_tx(arb_tx),
        .arb_oe(arb_oe), .arb_rx(arb_rx), .rx_word(rx_word), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx(tx), .bus_reset_active(bus_reset_active)
    );
    bpl_link_model M (
        .sclk(sclk), .ctl_out(ctl_out), .d_out(d_out), .lreq(lreq), .l_oe(l_oe),
        .l_ctl(l_ctl), .l_d(l_d)
    );
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic need(input bit c);
        chk("wait bound", 12'h001, {11'h000, c});
        if (!c)
            end_sim();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        M.send({1'h1, 3'h5, a, v, 1'h0}, 17);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        M.send({8'h00, 1'h1, 3'h4, a, 1'h0}, 9);
        M.status(w, ok);
        need(ok);
        chk("status", {a, e}, w);
    endtask
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    initial begin
        reset    = 1'h1;
        rival    = 1'h0;
        rx_valid = 1'h0;
        rx_word  = '0;
        n_errors = 0;
        n_checks = 0;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'h0;
        for (int a = 0; a < 16; a++)
            rd(4'(a), 8'h00);
        for (int a = 0; a < 16; a++) begin
            if (a == 1)
                continue;
            wr(4'(a), 8'hFF);
            rd(4'(a), a == 0 ? 8'h3F : a == 4 ? 8'h0F : 8'h00);
        end
        M.send({1'h1, 3'h5, 4'h4, 8'h09, 1'h1}, 17);
        rd(4'h4, 8'h0F);
        wr(4'h0, 8'h05);
        wr(4'h4, 8'h00);
        wr(4'h1, 8'h02);
        chk("bus reset on", 12'h001, {11'h000, bus_reset_active});
        repeat (RC - 2) @(posedge clk);
        #1;
        chk("bus reset held", 12'h001, {11'h000, bus_reset_active});
        repeat (4) @(posedge clk);
        #1;
        chk("bus reset off", 12'h000, {11'h000, bus_reset_active});
        rd(4'h1, 8'h00);
        $display("test registers done");
        rival = 1'h1;
        M.send(BUS_REQ, 11);
        repeat (16) M.tick();
        chk("outbid ctl", 12'h000, {10'h000, ctl_out});
        rival = 1'h0;
        M.grant(ok);
        need(ok);
        chk("handover", 12'h000, {10'h000, ctl_oe, d_oe});
        for (int i = 0; i < 4; i++) begin
            M.xmit(2'(i));
            chk("tx word", {8'h00, 2'(i), 2'h3}, {8'h00, tx});
        end
        M.release_bus();
        chk("retake", 12'h004, {9'h000, ctl_oe, ctl_out});
        wr(4'h1, 8'hFD);
        rd(4'h1, 8'h01);
        // urgent priority leads with a one, so it beats a rival that only asserts
        rival = 1'h1;
        M.send({6'h00, 1'h1, 3'h3, 2'h0, 4'h8, 1'h0}, 11);
        M.grant(ok);
        need(ok);
        rival = 1'h0;
        M.xmit(2'h3);
        chk("inhibited tx", 12'h000, {8'h00, tx});
        M.release_bus();
        wr(4'h1, 8'h00);
        $display("test arbitration done");
        full = 1'h0;
        k = 0;
        // ready lags a cycle, so only the first 16 words are sure to land
        for (int i = 0; i < 100 && !(full && rx_ready); i++) begin
            @(posedge clk);
            #1;
            full = full | !rx_ready;
            rx_valid = rx_ready;
            rx_word = '{last: full, dibit: 2'(k)};
            k += int'(rx_ready);
        end
        @(posedge clk);
        #1;
        rx_valid = 1'h0;
        need(full);
        M.wait_ctl(2'h0, ok);
        need(ok);
        for (int i = 0; i < 16; i++)
            chk("rx dibit", 12'(i % 4), {10'h000, M.rxq[i]});
        reset = 1'h1;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'h0;
        rd(4'h0, 8'h00);
        $display("test receive done");
        end_sim();
    end
endmodule // bpl_phy_link_test
